// ==== hdl/hotplug_slot_signal_config.sv ====
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "hp_consts.svh"

module hotplug_slot_signal_config
    import hp_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Slot pins, sensed
    input wire logic [`NPORT-1:0] attn_button_in_n,
    input wire logic [`NPORT-1:0] presence_detect_in_n,
    input wire logic [`NPORT-1:0] power_fault_in_n,
    input wire logic [`NPORT-1:0] latch_sensor_in_n,
    input wire logic [`NPORT-1:0] slot_power_good_in_n,
    // Slot pins, driven
    output logic [`NPORT-1:0] attn_indicator_out_n,
    output logic [`NPORT-1:0] power_indicator_out_n,
    output logic [`NPORT-1:0] slot_power_enable_out,
    output logic [`NPORT-1:0] interlock_drive_out,
    output logic [`NPORT-1:0] downstream_reset_out_n,
    // From hot-plug controllers and link logic
    input wire logic [`NPORT-1:0] receiver_detected,
    input wire logic [`NPORT-1:0] attn_indicator_on,
    input wire logic [`NPORT-1:0] power_indicator_on,
    input wire logic [`NPORT-1:0] power_controller_on,
    input wire logic [`NPORT-1:0] latch_present_capability,
    input wire logic [`NPORT-1:0] interlock_command,
    // To hot-plug controllers
    output logic [`NPORT-1:0] attn_button_pressed,
    output logic [`NPORT-1:0] presence_reported,
    output logic [`NPORT-1:0] power_fault_sensed,
    output logic [`NPORT-1:0] latch_open_sensed,
    output logic [`NPORT-1:0] lock_engaged_sensed,
    output logic [`NPORT-1:0] power_good_sensed
);

    state_t q;
    state_t d;

    logic [`NPORT-1:0] lat_s;
    logic [`NPORT-1:0] pg_s;
    logic [`NPORT-1:0] auto_off;
    logic [`NPORT-1:0] want;
    logic [`NPORT-1:0] stable;
    logic addr_rd;
    logic addr_wr;
    logic [31:0] cfg_now;
    logic [31:0] sts_now;

    // ------------------------------------------------------------------------
    // Sensed levels shared by sequencing and checks
    // ------------------------------------------------------------------------
    assign lat_s = ~latch_sensor_in_n ^ {`NPORT{q.cfg[`B_INV_LAT]}};
    assign pg_s = ~slot_power_good_in_n ^ {`NPORT{q.cfg[`B_INV_PG]}};
    // Latch open removes power whatever the controller asks; not in lock mode
    assign auto_off = {`NPORT{q.cfg[`B_AUTO_OFF] & ~q.cfg[`B_LAT_LOCK]}}
        & latch_present_capability & lat_s;
    assign want = power_controller_on & ~auto_off;
    // Reserved reset modes fall back to power enable control
    assign stable = (q.cfg[`F_RST_MODE] == `RST_PGC) ? pg_s : q.pwr_en;

    assign addr_rd = hsel & hready & htrans[1] & ~hwrite;
    assign addr_wr = hsel & hready & htrans[1] & hwrite;
    // Bypass a write still in its data phase so back-to-back reads see it
    assign cfg_now = (q.wr_pend && q.wr_addr == `CFG_OFS) ? hwdata : q.cfg;
    always_comb
    begin
        sts_now = 32'h0;
        sts_now[`F_STS_PEN] = q.pwr_en;
        sts_now[`F_STS_RSTN] = q.rst_neg;
        sts_now[`F_STS_ILK] = q.ilk_lvl;
        sts_now[`F_STS_PRES] = q.pres;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        d = q;
        d.tick = 1'b0;
        d.ready = 1'b1;

        // 10 ms tick divider
        if (q.tick_cnt == `TICK_W'(TICK_CYCLES - 1))
        begin
            d.tick_cnt = '0;
            d.tick = 1'b1;
        end
        else
        begin
            d.tick_cnt = q.tick_cnt + `TICK_W'(1);
        end

        // Bus: zero wait states, write lands in the data phase
        if (q.wr_pend && q.wr_addr == `CFG_OFS)
        begin
            d.cfg = hwdata;
        end
        d.wr_pend = addr_wr;
        d.wr_addr = haddr[`ADDR_W-1:0];
        if (addr_rd)
        begin
            if (haddr[`ADDR_W-1:0] == `CFG_OFS)
            begin
                d.rdata = cfg_now;
            end
            else if (haddr[`ADDR_W-1:0] == `STS_OFS)
            begin
                d.rdata = sts_now;
            end
            else
            begin
                d.rdata = 32'h0;
            end
        end

        for (int i = 0; i < `NPORT; i++)
        begin
            // Sensed inputs toward the controllers
            d.btn[i] = ~attn_button_in_n[i] ^ q.cfg[`B_INV_BTN];
            d.flt[i] = ~power_fault_in_n[i] ^ q.cfg[`B_INV_FLT];
            d.pgood[i] = pg_s[i];
            d.lat_open[i] = lat_s[i] & ~q.cfg[`B_LAT_LOCK];
            d.lock[i] = lat_s[i] & q.cfg[`B_LAT_LOCK];
            case (q.cfg[`F_PRES])
                `PRES_BOTH: d.pres[i] = receiver_detected[i]
                    | (~presence_detect_in_n[i] ^ q.cfg[`B_INV_PRES]);
                `PRES_SIGNAL: d.pres[i] = ~presence_detect_in_n[i]
                    ^ q.cfg[`B_INV_PRES];
                `PRES_ALWAYS: d.pres[i] = 1'b1;
                default: d.pres[i] = 1'b0;
            endcase

            // Power and reset sequencing
            case (q.st[i])
                PS_OFF:
                begin
                    if (want[i])
                    begin
                        d.pwr_en[i] = 1'b1;
                        d.st[i] = PS_RAMP;
                    end
                end
                PS_RAMP:
                begin
                    if (!want[i])
                    begin
                        d.pwr_en[i] = 1'b0;
                        d.st[i] = PS_OFF;
                    end
                    else if (stable[i])
                    begin
                        d.dly[i] = q.cfg[`F_POWER_TO_RESET_DELAY];
                        d.st[i] = PS_HOLD;
                    end
                end
                PS_HOLD:
                begin
                    // Reset never negated yet, so power may drop at once
                    if (!want[i])
                    begin
                        d.pwr_en[i] = 1'b0;
                        d.st[i] = PS_OFF;
                    end
                    // First tick is partial; one more keeps the wait a full delay
                    else if (q.dly[i] == '0 && (q.tick || q.cfg[`F_POWER_TO_RESET_DELAY] == '0))
                    begin
                        d.rst_neg[i] = 1'b1;
                        d.st[i] = PS_ON;
                    end
                    else if (q.tick)
                    begin
                        d.dly[i] = q.dly[i] - `DLY_W'(1);
                    end
                end
                PS_ON:
                begin
                    if (!want[i])
                    begin
                        d.rst_neg[i] = 1'b0;
                        d.dly[i] = q.cfg[`F_RESET_TO_POWER_OFF_DELAY];
                        d.st[i] = PS_DRAIN;
                    end
                end
                PS_DRAIN:
                begin
                    // A new request waits for the power-off to finish
                    if (q.dly[i] == '0 && (q.tick || q.cfg[`F_RESET_TO_POWER_OFF_DELAY] == '0))
                    begin
                        d.pwr_en[i] = 1'b0;
                        d.st[i] = PS_OFF;
                    end
                    else if (q.tick)
                    begin
                        d.dly[i] = q.dly[i] - `DLY_W'(1);
                    end
                end
                default:
                begin
                    d.pwr_en[i] = 1'b0;
                    d.rst_neg[i] = 1'b0;
                    d.st[i] = PS_OFF;
                end
            endcase

            // Interlock: pulse in whole ticks, or toggle
            if (interlock_command[i])
            begin
                if (q.cfg[`B_ILK_TOG])
                begin
                    d.ilk_lvl[i] = ~q.ilk_lvl[i];
                    d.ilk_cnt[i] = '0;
                end
                else
                begin
                    d.ilk_lvl[i] = 1'b1;
                    d.ilk_cnt[i] = `ILK_W'(`ILK_TICKS);
                end
            end
            else if (q.tick && q.ilk_cnt[i] != '0)
            begin
                d.ilk_cnt[i] = q.ilk_cnt[i] - `ILK_W'(1);
                if (q.ilk_cnt[i] == `ILK_W'(1))
                begin
                    d.ilk_lvl[i] = 1'b0;
                end
            end

            // Pin drivers
            d.aind_n[i] = ~attn_indicator_on[i] ^ q.cfg[`B_INV_AIND];
            d.pind_n[i] = ~power_indicator_on[i] ^ q.cfg[`B_INV_PIND];
            d.pen_out[i] = d.pwr_en[i] ^ q.cfg[`B_INV_PEN];
            d.ilk_out[i] = d.ilk_lvl[i] ^ q.cfg[`B_INV_ILK];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            q <= '0;
            q.cfg <= `CFG_RST;
            q.ready <= 1'b1;
            q.aind_n <= '1;
            q.pind_n <= '1;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign hreadyout = q.ready;
    assign hrdata = q.rdata;
    assign hresp = 1'b0;
    assign attn_indicator_out_n = q.aind_n;
    assign power_indicator_out_n = q.pind_n;
    assign slot_power_enable_out = q.pen_out;
    assign interlock_drive_out = q.ilk_out;
    assign downstream_reset_out_n = q.rst_neg;
    assign attn_button_pressed = q.btn;
    assign presence_reported = q.pres;
    assign power_fault_sensed = q.flt;
    assign latch_open_sensed = q.lat_open;
    assign lock_engaged_sensed = q.lock;
    assign power_good_sensed = q.pgood;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_button_sense: assert property (
        ##1 attn_button_pressed == $past(~attn_button_in_n ^ {`NPORT{q.cfg[`B_INV_BTN]}}))
        else $error("attention button sense wrong");

    a_pres_forced: assert property (
        q.cfg[`F_PRES] == `PRES_NEVER && $stable(q.cfg) |=> presence_reported == '0)
        else $error("presence not forced absent");

    a_pres_signal: assert property (
        q.cfg[`F_PRES] == `PRES_SIGNAL && $stable(q.cfg)
        |=> presence_reported == $past(~presence_detect_in_n ^ {`NPORT{q.cfg[`B_INV_PRES]}}))
        else $error("presence signal mode wrong");

    a_pen_polarity: assert property (
        slot_power_enable_out == (q.pwr_en ^ {`NPORT{$past(q.cfg[`B_INV_PEN])}}))
        else $error("power enable polarity wrong");

    a_latch_off: assert property (
        q.st[0] == PS_ON && auto_off[0] |=> q.st[0] == PS_DRAIN && !downstream_reset_out_n[0])
        else $error("latch open did not start power off");

    a_reset_power: assert property (
        $rose(downstream_reset_out_n[0]) |-> q.pwr_en[0] && $past(q.dly[0]) == '0)
        else $error("reset negated early");

    a_power_reset: assert property (
        $fell(q.pwr_en[0]) && $past(q.st[0]) == PS_DRAIN
        |-> !downstream_reset_out_n[0] && $past(q.dly[0]) == '0)
        else $error("power removed before delay");

    a_ilock_toggle: assert property (
        interlock_command[0] && q.cfg[`B_ILK_TOG] |=> q.ilk_lvl[0] != $past(q.ilk_lvl[0]))
        else $error("interlock did not toggle");

    a_ilock_pulse: assert property (
        interlock_command[0] && !q.cfg[`B_ILK_TOG]
        |=> q.ilk_lvl[0] && q.ilk_cnt[0] == `ILK_W'(`ILK_TICKS))
        else $error("interlock pulse not started");

    a_delay_load: assert property (
        q.st[0] == PS_RAMP && want[0] && stable[0] |=> q.dly[0] == $past(q.cfg[`F_POWER_TO_RESET_DELAY]))
        else $error("delay counter not loaded");

    a_fault_sense: assert property (
        ##1 power_fault_sensed == $past(~power_fault_in_n ^ {`NPORT{q.cfg[`B_INV_FLT]}}))
        else $error("power fault sense wrong");

    a_lock_sense: assert property (
        ##1 lock_engaged_sensed == $past(lat_s & {`NPORT{q.cfg[`B_LAT_LOCK]}}))
        else $error("lock state sense wrong");

    a_ilock_polarity: assert property (
        interlock_drive_out == (q.ilk_lvl ^ {`NPORT{$past(q.cfg[`B_INV_ILK])}}))
        else $error("interlock polarity wrong");

    a_pres_both: assert property (
        q.cfg[`F_PRES] == `PRES_BOTH
        |=> presence_reported == $past(receiver_detected
            | (~presence_detect_in_n ^ {`NPORT{q.cfg[`B_INV_PRES]}})))
        else $error("presence both mode wrong");

    a_aind_polarity: assert property (
        ##1 attn_indicator_out_n == $past(~attn_indicator_on ^ {`NPORT{q.cfg[`B_INV_AIND]}}))
        else $error("attention indicator polarity wrong");

    a_pgood_sense: assert property (
        ##1 power_good_sensed == $past(~slot_power_good_in_n ^ {`NPORT{q.cfg[`B_INV_PG]}}))
        else $error("power good sense wrong");

    a_reset_wait: assert property (
        $rose(downstream_reset_out_n[0]) |-> $past(q.tick) || $past(q.cfg[`F_POWER_TO_RESET_DELAY]) == '0)
        else $error("reset negated before a full delay");

    c_power_up: cover property ($rose(downstream_reset_out_n[0]));
    c_power_down: cover property ($fell(q.pwr_en[0]) && $past(q.st[0]) == PS_DRAIN);
    c_ilock_end: cover property ($fell(q.ilk_lvl[0]) && !q.cfg[`B_ILK_TOG]);
    c_latch_off: cover property (q.st[0] == PS_ON && auto_off[0]);
    c_ilock_toggle: cover property (interlock_command[0] && q.cfg[`B_ILK_TOG]);

endmodule

`default_nettype wire

// ==== hdl/hp_consts.svh ====
// Functional notes
// - Attention button input sensed inverted in every port when its invert bit is set.
// - Presence detect input sensed inverted in every port when its invert bit is set.
// - Power fault input sensed inverted in every port when its invert bit is set.
// - Latch sensor input sensed inverted in every port when its invert bit is set.
// - Attention indicator output driven inverted in every port when its bit is set.
// - Power indicator output driven inverted in every port when its bit is set.
// - Slot power enable output driven inverted in every port when its bit is set.
// - Interlock output driven inverted in every port when its bit is set.
// - Power good input sensed inverted in every port when its invert bit is set.
// - Presence select zero reports receiver detect OR presence detect input.
// - Presence select one reports the presence detect input alone.
// - Presence select two reports always present; three reports always absent.
// - Latch open with auto power-off bit and latch capability removes power; default on.
// - Latch-open power removal overrides the software power controller setting.
// - Latch-as-lock bit makes latch sensor inputs report lock state instead.
// - Toggle mode clear: interlock command pulses interlock between 100 and 150 ms.
// - Toggle mode set: each interlock command inverts the interlock output level.
// - Reset mode zero: reset follows power enable; one: follows power good.
// - Wait power-to-reset delay, 10 ms units, default 20, before negating reset.
// - Wait reset-to-power-off delay, 10 ms units, default 20, before removing power.
`ifndef HP_CONSTS_SVH
`define HP_CONSTS_SVH

`define NPORT 4

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define ADDR_W 12
`define CFG_OFS 12'h408
`define STS_OFS 12'h40c
`define CFG_RST 32'h1414_0800

`define B_INV_BTN 0
`define B_INV_PRES 1
`define B_INV_FLT 2
`define B_INV_LAT 3
`define B_INV_AIND 4
`define B_INV_PIND 5
`define B_INV_PEN 6
`define B_INV_ILK 7
`define B_INV_PG 8
`define F_PRES 10:9
`define B_AUTO_OFF 11
`define B_LAT_LOCK 12
`define B_ILK_TOG 13
`define F_RST_MODE 15:14
`define F_POWER_TO_RESET_DELAY 23:16
`define F_RESET_TO_POWER_OFF_DELAY 31:24

`define F_STS_PEN 3:0
`define F_STS_RSTN 7:4
`define F_STS_ILK 11:8
`define F_STS_PRES 15:12

`define PRES_BOTH 2'h0
`define PRES_SIGNAL 2'h1
`define PRES_ALWAYS 2'h2
`define PRES_NEVER 2'h3
`define RST_PGC 2'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 250
`define TICK_MS 10
`define ILK_MIN_MS 100
`define ILK_MAX_MS 150
`define TICK_CYCLES (`TICK_MS * 1000 * `CLK_MHZ)
// One extra tick covers the partial first tick
`define ILK_TICKS (`ILK_MIN_MS / `TICK_MS + 1)
`define TICK_W 22
`define DLY_W 8
`define ILK_W 4

`endif

// ==== hdl/hp_pkg.sv ====
`include "hp_consts.svh"

package hp_pkg;

    typedef enum logic [2:0] {PS_OFF, PS_RAMP, PS_HOLD, PS_ON, PS_DRAIN} pwr_state_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic wr_pend;
        logic [`ADDR_W-1:0] wr_addr;
        logic [31:0] rdata;
        logic ready;
        logic [`TICK_W-1:0] tick_cnt;
        logic tick;
        pwr_state_t [`NPORT-1:0] st;
        logic [`NPORT-1:0][`DLY_W-1:0] dly;
        logic [`NPORT-1:0] pwr_en;
        logic [`NPORT-1:0] rst_neg;
        logic [`NPORT-1:0] ilk_lvl;
        logic [`NPORT-1:0][`ILK_W-1:0] ilk_cnt;
        logic [`NPORT-1:0] aind_n;
        logic [`NPORT-1:0] pind_n;
        logic [`NPORT-1:0] pen_out;
        logic [`NPORT-1:0] ilk_out;
        logic [`NPORT-1:0] btn;
        logic [`NPORT-1:0] pres;
        logic [`NPORT-1:0] flt;
        logic [`NPORT-1:0] lat_open;
        logic [`NPORT-1:0] lock;
        logic [`NPORT-1:0] pgood;
    } state_t;

endpackage

// ==== dv/slot_power_model.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "hp_consts.svh"

module slot_power_model
#(
    parameter int PG_DLY = 40
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Board polarity of the enable pin
    input wire logic pen_low,
    // Slot power pins
    input wire logic [`NPORT-1:0] slot_power_enable_out,
    output logic [`NPORT-1:0] slot_power_good_in_n
);
    int cnt [`NPORT];

    // ------------------------------------------------------------
    // Supply ramp
    // ------------------------------------------------------------
    // Unknown enable counts as off, so a floating pin never powers up
    always @(posedge hclk or negedge hresetn)
    begin
        for (int i = 0; i < `NPORT; i++)
        begin
            if (!hresetn || slot_power_enable_out[i] !== ~pen_low)
                cnt[i] <= 0;
            else if (cnt[i] < PG_DLY)
                cnt[i] <= cnt[i] + 1;
        end
    end

    // Good drops at once on removal, rises only after a full ramp
    always_comb
    begin
        for (int i = 0; i < `NPORT; i++)
            slot_power_good_in_n[i] = !(cnt[i] >= PG_DLY);
    end
endmodule
`default_nettype wire

// ==== dv/test_hotplug_slot_signal_config.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "hp_consts.svh"

module test_hotplug_slot_signal_config;
    localparam int TICK = 10;
    localparam int PG_DLY = 40;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    logic [3:0] btn_n = 4'hf, pres_n = 4'hf, flt_n = 4'hf, lat_n = 4'hf;
    logic [3:0] rx = 4'h0, aon = 4'h0, pon = 4'h0, pco = 4'h0, lcap = 4'h0, icmd = 4'h0;
    logic [3:0] pg_n, aind_n, pind_n, pen, ilk, rst_n;
    logic [3:0] btn_s, pres_s, flt_s, lat_s, lock_s, pg_s;
    logic pen_low = 1'b0;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_0061;

    always #2 hclk = ~hclk;

    hotplug_slot_signal_config #(.TICK_CYCLES(TICK)) dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .attn_button_in_n(btn_n), .presence_detect_in_n(pres_n), .power_fault_in_n(flt_n),
        .latch_sensor_in_n(lat_n), .slot_power_good_in_n(pg_n),
        .attn_indicator_out_n(aind_n), .power_indicator_out_n(pind_n),
        .slot_power_enable_out(pen), .interlock_drive_out(ilk), .downstream_reset_out_n(rst_n),
        .receiver_detected(rx), .attn_indicator_on(aon), .power_indicator_on(pon),
        .power_controller_on(pco), .latch_present_capability(lcap), .interlock_command(icmd),
        .attn_button_pressed(btn_s), .presence_reported(pres_s), .power_fault_sensed(flt_s),
        .latch_open_sensed(lat_s), .lock_engaged_sensed(lock_s), .power_good_sensed(pg_s));

    slot_power_model #(.PG_DLY(PG_DLY)) supply (.hclk(hclk), .hresetn(hresetn),
        .pen_low(pen_low), .slot_power_enable_out(pen), .slot_power_good_in_n(pg_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: saw %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(q, exp, msg);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge hclk);
    endtask

    task automatic pulse_cmd(input logic [3:0] p);
        @(posedge hclk);
        icmd <= p;
        @(posedge hclk);
        icmd <= 4'h0;
    endtask

    function automatic logic pick(input int sel, input int p);
        return (sel == 0) ? ilk[p] : (sel == 1) ? pen[p] : rst_n[p];
    endfunction

    // Cycles for which the chosen output holds lvl, bounded so a stuck one fails
    task automatic span(input int sel, input int p, input logic lvl, output int n);
        n = 0;
        while (pick(sel, p) === lvl && n < 600)
        begin
            @(negedge hclk);
            n++;
        end
    endtask

    task automatic in_range(input int n, input int lo, input int hi, input string msg);
        check({31'h0, n >= lo && n <= hi}, 32'h1, msg);
    endtask

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            failures++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] c, q;
        logic [3:0] e;
        int n;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`CFG_OFS, `CFG_RST, "config reset value");
        wr(32'h0000_0404, 32'hffff_ffff);
        rd(32'h0000_0404, 32'h0, "unmapped read");
        rd(`CFG_OFS, `CFG_RST, "config after unmapped write");
        check(hresp, 1'b0, "bus response");
        for (int k = 0; k < 40; k++)
        begin
            c = rnd();
            c[13] = 1'b0;
            c[15] = 1'b0;
            pen_low <= c[6];
            wr(`CFG_OFS, c);
            rd(`CFG_OFS, c, "config readback");
            q = rnd();
            @(posedge hclk);
            {lcap, pon, aon, rx, lat_n, flt_n, pres_n, btn_n} <= q;
            cyc(3);
            e = ~btn_n ^ {4{c[0]}};
            check(btn_s, e, "button sense");
            e = ~pres_n ^ {4{c[1]}};
            e = (c[10:9] == 2'h0) ? (e | rx) : (c[10:9] == 2'h1) ? e : {4{~c[9]}};
            check(pres_s, e, "presence report");
            e = ~flt_n ^ {4{c[2]}};
            check(flt_s, e, "fault sense");
            e = ~lat_n ^ {4{c[3]}};
            check(lat_s, e & {4{~c[12]}}, "latch sense");
            check(lock_s, e & {4{c[12]}}, "lock sense");
            e = ~aon ^ {4{c[4]}};
            check(aind_n, e, "attention indicator");
            e = ~pon ^ {4{c[5]}};
            check(pind_n, e, "power indicator");
            check(pen, {4{c[6]}}, "power enable idle");
            check(ilk, {4{c[7]}}, "interlock idle");
            check(pg_s, {4{c[8]}}, "power good sense");
        end
        pen_low <= 1'b0;
        @(posedge hclk);
        {lcap, pon, aon, rx, lat_n, flt_n, pres_n, btn_n} <= 32'h0000_ffff;
        wr(`CFG_OFS, 32'h0000_0080);
        pulse_cmd(4'h5);
        cyc(1);
        span(0, 2, 1'b0, n);
        in_range(n, 100, 150, "interlock pulse width");
        wr(`CFG_OFS, 32'h0000_2000);
        pulse_cmd(4'h3);
        cyc(2);
        check(ilk, 4'h3, "interlock toggled on");
        cyc(160);
        check(ilk, 4'h3, "interlock level held");
        pulse_cmd(4'h3);
        cyc(2);
        check(ilk, 4'h0, "interlock toggled off");
        wr(`CFG_OFS, 32'h0302_0000);
        @(posedge hclk);
        pco <= 4'h1;
        cyc(2);
        check(pen, 4'h1, "power enabled");
        span(2, 0, 1'b0, n);
        in_range(n, 18, 32, "power to reset delay");
        @(posedge hclk);
        pco <= 4'h3;
        cyc(2);
        span(2, 1, 1'b0, n);
        in_range(n, 18, 32, "second port delay");
        @(posedge hclk);
        pco <= 4'h2;
        cyc(2);
        check(rst_n, 4'h2, "reset asserted before power off");
        span(1, 0, 1'b1, n);
        in_range(n, 28, 42, "reset to power off delay");
        check(pen, 4'h2, "other port still powered");
        @(posedge hclk);
        pco <= 4'h0;
        cyc(60);
        // Zero delay in power-good mode: negation waits only on the supply
        wr(`CFG_OFS, 32'h0300_4000);
        @(posedge hclk);
        pco <= 4'h4;
        cyc(2);
        span(2, 2, 1'b0, n);
        in_range(n, PG_DLY - 2, PG_DLY + 12, "reset follows power good");
        @(posedge hclk);
        pco <= 4'h0;
        cyc(60);
        wr(`CFG_OFS, 32'h0300_1800);
        @(posedge hclk);
        lcap <= 4'h1;
        lat_n <= 4'he;
        pco <= 4'h1;
        cyc(40);
        check(pen, 4'h1, "lock input keeps power");
        check(lock_s, 4'h1, "lock state reported");
        rd(`STS_OFS, 32'h0000_0011, "status after power-up");
        wr(`CFG_OFS, 32'h0300_0800);
        span(1, 0, 1'b1, n);
        in_range(n, 28, 44, "latch open removes power");
        check(pen, 4'h0, "power stays off with latch open");
        give_verdict();
    end
endmodule
`default_nettype wire
